/* File: otp_host.sv */
// Host controller for OTP lock, OTP page read, write protect and power-up of a NAND part
`timescale 1ns/1ps
`default_nettype none
module otp_host #(
  parameter int POWER_WAIT = otp_host_pkg::POWER_WAIT_CYC,
  parameter int POR_TIMEOUT = otp_host_pkg::POR_RESET_CYC,
  parameter int PROG_TIMEOUT = otp_host_pkg::PAGE_PROGRAM_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic o_wp_n,
  output logic [7:0] o_io,
  output logic o_io_oe_n,
  input wire logic [7:0] i_io,
  input wire logic i_ready_busy_n
);
  typedef enum {
    ST_IDLE, ST_PWR, ST_SETUP, ST_CMD, ST_ADDR, ST_WB, ST_BUSY, ST_RDSTAT, ST_RDDATA, ST_HOLD
  } state_t;

  // Bus step kinds
  typedef enum {K_CMD, K_ADDR, K_END} kind_t;

  // Pin synchronisers
  logic [1:0] rb_sync_r, rb_sync_nxt;
  logic [7:0] io_s1_r, io_s2_r, io_s_nxt;

  state_t state_r, state_nxt;
  logic [3:0] step_r, step_nxt;
  logic [2:0] op_r, op_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [15:0] col_r, col_nxt;
  logic [7:0] page_r, page_nxt;
  logic wp_n_r, wp_n_nxt;
  logic [7:0] dev_st_r, dev_st_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] irq_st_r, irq_st_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic inited_r, inited_nxt;
  logic ce_n_r, ce_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt, we_n_r, we_n_nxt, re_n_r, re_n_nxt;
  logic [7:0] io_r, io_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic irq_r, irq_nxt;
  logic busy;

  // Byte driven at a given step of the chosen sequence, and its kind
  function automatic logic [7:0] seq_byte(input logic [2:0] op, input logic [3:0] st,
                                          input logic [15:0] col, input logic [7:0] pg);
    logic [7:0] b;
    b = otp_host_pkg::CMD_RESET;
    case (op)
      otp_host_pkg::OP_LOCK:
        case (st)
          4'h0: b = otp_host_pkg::CMD_OTP_LOCK;
          4'h1: b = otp_host_pkg::LOCK_ADDR0;
          4'h2: b = otp_host_pkg::LOCK_ADDR1;
          4'h3: b = otp_host_pkg::LOCK_ADDR2;
          4'h4: b = otp_host_pkg::LOCK_ADDR3;
          default: b = otp_host_pkg::CMD_PROG_CONFIRM;
        endcase
      otp_host_pkg::OP_READ:
        case (st)
          4'h0: b = otp_host_pkg::CMD_OTP_READ;
          4'h1: b = col[7:0];
          4'h2: b = col[15:8];
          4'h3: b = pg;
          4'h4: b = 8'h00;
          default: b = otp_host_pkg::CMD_READ_CONFIRM;
        endcase
      otp_host_pkg::OP_RAND:
        case (st)
          4'h0: b = otp_host_pkg::CMD_RAND_OUT;
          4'h1: b = col[7:0];
          4'h2: b = col[15:8];
          default: b = otp_host_pkg::CMD_RAND_OUT_CONFIRM;
        endcase
      otp_host_pkg::OP_STATUS: b = otp_host_pkg::CMD_READ_STATUS;
      default: b = otp_host_pkg::CMD_RESET;
    endcase
    return b;
  endfunction

  function automatic kind_t seq_kind(input logic [2:0] op, input logic [3:0] st);
    kind_t k;
    k = K_END;
    case (op)
      otp_host_pkg::OP_LOCK, otp_host_pkg::OP_READ:
        k = (st == 4'h0 || st == 4'h5) ? K_CMD : (st < 4'h5 ? K_ADDR : K_END);
      otp_host_pkg::OP_RAND:
        k = (st == 4'h0 || st == 4'h3) ? K_CMD : (st < 4'h3 ? K_ADDR : K_END);
      default: k = (st == 4'h0) ? K_CMD : K_END;
    endcase
    if ((op == otp_host_pkg::OP_LOCK || op == otp_host_pkg::OP_READ) && st > 4'h5)
      k = K_END;
    if (op == otp_host_pkg::OP_RAND && st > 4'h3)
      k = K_END;
    if (op != otp_host_pkg::OP_LOCK && op != otp_host_pkg::OP_READ &&
        op != otp_host_pkg::OP_RAND && st > 4'h0)
      k = K_END;
    return k;
  endfunction

  assign busy = (state_r != ST_IDLE);

  // Sequencer, register file and pin drive
  always_comb
  begin
    rb_sync_nxt = {rb_sync_r[0], i_ready_busy_n};
    io_s_nxt = i_io;
    state_nxt = state_r;
    step_nxt = step_r;
    op_nxt = op_r;
    cnt_nxt = (cnt_r != 24'h000000) ? cnt_r - 24'h000001 : cnt_r;
    ph_nxt = ph_r;
    col_nxt = col_r;
    page_nxt = page_r;
    wp_n_nxt = wp_n_r;
    dev_st_nxt = dev_st_r;
    rdata_nxt = rdata_r;
    mask_nxt = mask_r;
    inited_nxt = inited_r;
    ce_n_nxt = ce_n_r;
    cle_nxt = 1'b0;
    ale_nxt = 1'b0;
    we_n_nxt = 1'b1;
    re_n_nxt = 1'b1;
    io_nxt = io_r;
    oe_n_nxt = oe_n_r;
    irq_st_nxt = irq_st_r;
    rd_nxt = 32'h00000000;
    // Register reads; IRQ register read clears sticky bits below
    if (i_rd)
    begin
      case (i_addr)
        otp_host_pkg::REG_CTRL: rd_nxt = {31'h00000000, wp_n_r};
        otp_host_pkg::REG_ADDR: rd_nxt = {8'h00, page_r, col_r};
        otp_host_pkg::REG_STATUS: rd_nxt = {29'h00000000, inited_r, ~rb_sync_r[1], busy};
        otp_host_pkg::REG_DEV_STATUS: rd_nxt = {24'h000000, dev_st_r};
        otp_host_pkg::REG_RDATA: rd_nxt = {24'h000000, rdata_r};
        otp_host_pkg::REG_IRQ: rd_nxt = {29'h00000000, irq_st_r};
        otp_host_pkg::REG_MASK: rd_nxt = {29'h00000000, mask_r};
        default: rd_nxt = 32'h00000000;
      endcase
      if (i_addr == otp_host_pkg::REG_IRQ)
        irq_st_nxt = 3'h0;
    end
    if (i_wr)
    begin
      case (i_addr)
        otp_host_pkg::REG_ADDR:
        begin
          col_nxt = i_wdata[15:0];
          page_nxt = i_wdata[23:16];
        end
        otp_host_pkg::REG_MASK: mask_nxt = i_wdata[2:0];
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE:
      begin
        ce_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        if (i_wr && i_addr == otp_host_pkg::REG_CTRL)
        begin
          op_nxt = i_wdata[3:1];
          step_nxt = 4'h0;
          if (i_wdata[3:1] == otp_host_pkg::OP_INIT)
          begin
            wp_n_nxt = 1'b0;
            cnt_nxt = 24'(POWER_WAIT);
            state_nxt = ST_PWR;
          end
          else if (!inited_r)
            irq_st_nxt[otp_host_pkg::IRQ_FAIL] = 1'b1;
          else if (i_wdata[3:1] == otp_host_pkg::OP_READ &&
                   (page_r < otp_host_pkg::OTP_PAGE_FIRST || page_r > otp_host_pkg::OTP_PAGE_LAST))
            irq_st_nxt[otp_host_pkg::IRQ_BADPAGE] = 1'b1;
          else if (i_wdata[3:1] == otp_host_pkg::OP_DATA)
          begin
            ce_n_nxt = 1'b0;
            state_nxt = ST_RDDATA;
            ph_nxt = 2'h0;
          end
          else if (i_wdata[3:1] != 3'h0)
          begin
            // WP set only while idle, then held through the operation
            wp_n_nxt = i_wdata[0];
            cnt_nxt = 24'(otp_host_pkg::WP_SETUP_CYC);
            state_nxt = ST_SETUP;
          end
        end
      end
      ST_PWR:
        // wait for ready high, or until the 100us power wait runs out
        if (rb_sync_r[1] || cnt_r == 24'h000000)
        begin
          op_nxt = otp_host_pkg::OP_RESET;
          state_nxt = ST_SETUP;
          cnt_nxt = 24'(otp_host_pkg::WP_SETUP_CYC);
        end
      ST_SETUP:
        if (cnt_r == 24'h000000)
        begin
          ce_n_nxt = 1'b0;
          state_nxt = ST_CMD;
          ph_nxt = 2'h0;
        end
      ST_CMD:
      begin
        // Two-cycle write: strobe low with data, then rising edge latches
        ph_nxt = ph_r + 2'h1;
        oe_n_nxt = 1'b0;
        io_nxt = seq_byte(op_r, step_r, col_r, page_r);
        cle_nxt = (seq_kind(op_r, step_r) == K_CMD);
        ale_nxt = (seq_kind(op_r, step_r) == K_ADDR);
        we_n_nxt = (ph_r != 2'h0);
        if (ph_r == 2'h1)
        begin
          ph_nxt = 2'h0;
          step_nxt = step_r + 4'h1;
          if (seq_kind(op_r, step_r + 4'h1) == K_END)
          begin
            // Wait covers the busy delay plus the synchroniser, else stale ready
            cnt_nxt = 24'(otp_host_pkg::WB_CYC + otp_host_pkg::RB_SYNC_LAG_CYC);
            state_nxt = ST_WB;
          end
        end
      end
      ST_WB:
      begin
        // Bus released a cycle after the last latch so data hold is kept
        oe_n_nxt = 1'b1;
        if (cnt_r == 24'h000000)
        begin
          if (op_r == otp_host_pkg::OP_STATUS || op_r == otp_host_pkg::OP_RAND)
          begin
            state_nxt = (op_r == otp_host_pkg::OP_STATUS) ? ST_RDSTAT : ST_RDDATA;
            ph_nxt = 2'h0;
          end
          else
          begin
            case (op_r)
              otp_host_pkg::OP_LOCK: cnt_nxt = 24'(PROG_TIMEOUT);
              otp_host_pkg::OP_READ: cnt_nxt = 24'(otp_host_pkg::ARRAY_LOAD_CYC);
              default: cnt_nxt = inited_r ? 24'(otp_host_pkg::CMD_RESET_CYC) : 24'(POR_TIMEOUT);
            endcase
            state_nxt = ST_BUSY;
          end
        end
      end
      ST_BUSY:
        if (rb_sync_r[1])
        begin
          // Ready returned: check status for lock result
          if (op_r == otp_host_pkg::OP_LOCK)
          begin
            op_nxt = otp_host_pkg::OP_STATUS;
            step_nxt = 4'h0;
            ph_nxt = 2'h0;
            state_nxt = ST_CMD;
          end
          else
          begin
            if (op_r == otp_host_pkg::OP_RESET)
              inited_nxt = 1'b1;
            irq_st_nxt[otp_host_pkg::IRQ_DONE] = 1'b1;
            state_nxt = ST_HOLD;
          end
        end
        else if (cnt_r == 24'h000000)
        begin
          irq_st_nxt[otp_host_pkg::IRQ_FAIL] = 1'b1;
          state_nxt = ST_HOLD;
        end
      ST_RDSTAT, ST_RDDATA:
      begin
        // Read cycle: RE low three cycles, sample synchronised bus, then release
        ph_nxt = ph_r + 2'h1;
        re_n_nxt = (ph_r == 2'h3);
        if (ph_r == 2'h3)
        begin
          if (state_r == ST_RDSTAT)
          begin
            dev_st_nxt = io_s2_r;
            if (!io_s2_r[otp_host_pkg::ST_PASS_BIT])
              irq_st_nxt[otp_host_pkg::IRQ_DONE] = 1'b1;
            else
              irq_st_nxt[otp_host_pkg::IRQ_FAIL] = 1'b1;
          end
          else
          begin
            rdata_nxt = io_s2_r;
            irq_st_nxt[otp_host_pkg::IRQ_DONE] = 1'b1;
          end
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // Chip stays selected for one more cycle, then idle deselects it
        ce_n_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    irq_nxt = |(irq_st_nxt & mask_r);
  end

  // Registered state
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      rb_sync_r <= 2'h0;
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
      state_r <= ST_IDLE;
      step_r <= 4'h0;
      op_r <= 3'h0;
      cnt_r <= 24'h000000;
      ph_r <= 2'h0;
      col_r <= 16'h0000;
      page_r <= 8'h00;
      wp_n_r <= 1'b0;
      dev_st_r <= 8'h00;
      rdata_r <= 8'h00;
      irq_st_r <= 3'h0;
      mask_r <= 3'h0;
      inited_r <= 1'b0;
      ce_n_r <= 1'b1;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      io_r <= 8'h00;
      oe_n_r <= 1'b1;
      rd_r <= 32'h00000000;
      irq_r <= 1'b0;
    end
    else
    begin
      rb_sync_r <= rb_sync_nxt;
      io_s1_r <= io_s_nxt;
      io_s2_r <= io_s1_r;
      state_r <= state_nxt;
      step_r <= step_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
      col_r <= col_nxt;
      page_r <= page_nxt;
      wp_n_r <= wp_n_nxt;
      dev_st_r <= dev_st_nxt;
      rdata_r <= rdata_nxt;
      irq_st_r <= irq_st_nxt;
      mask_r <= mask_nxt;
      inited_r <= inited_nxt;
      ce_n_r <= ce_n_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      we_n_r <= we_n_nxt;
      re_n_r <= re_n_nxt;
      io_r <= io_nxt;
      oe_n_r <= oe_n_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_rdata = rd_r;
  assign o_irq = irq_r;
  assign o_ce_n = ce_n_r;
  assign o_cle = cle_r;
  assign o_ale = ale_r;
  assign o_we_n = we_n_r;
  assign o_re_n = re_n_r;
  assign o_wp_n = wp_n_r;
  assign o_io = io_r;
  assign o_io_oe_n = oe_n_r;
endmodule // otp_host
`default_nettype wire

/* File: otp_host_pkg.sv */
// Package with command codes, register map and timing for the OTP host controller
package otp_host_pkg;
  localparam logic [7:0] CMD_OTP_LOCK = 8'hA5;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_OTP_READ = 8'hAF;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_RAND_OUT = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_CONFIRM = 8'hE0;
  localparam logic [7:0] LOCK_ADDR0 = 8'h00;
  localparam logic [7:0] LOCK_ADDR1 = 8'h00;
  localparam logic [7:0] LOCK_ADDR2 = 8'h01;
  localparam logic [7:0] LOCK_ADDR3 = 8'h00;
  localparam logic [7:0] OTP_PAGE_FIRST = 8'h02;
  localparam logic [7:0] OTP_PAGE_LAST = 8'h0B;
  // Status bit positions
  localparam int ST_PASS_BIT = 0;
  localparam int ST_RDY_BIT = 5;
  localparam int ST_ARRAY_RDY_BIT = 6;
  localparam int ST_UNLOCKED_BIT = 7;
  // Register offsets (word index on the local port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_DEV_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_IRQ = 4'h5;
  localparam logic [3:0] REG_MASK = 4'h6;
  // Control command codes
  localparam logic [2:0] OP_INIT = 3'h1;
  localparam logic [2:0] OP_LOCK = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_STATUS = 3'h4;
  localparam logic [2:0] OP_RAND = 3'h5;
  localparam logic [2:0] OP_DATA = 3'h6;
  localparam logic [2:0] OP_RESET = 3'h7;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_BADPAGE = 2;
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int WP_SETUP_NS = 100;
  localparam int WP_SETUP_CYC = (WP_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int POWER_WAIT_US = 100;
  localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
  localparam int WB_NS = 100;
  localparam int WB_CYC = (WB_NS * CLK_MHZ + 999) / 1000;
  // Ready/busy passes two flops, so busy shows up this much later
  localparam int RB_SYNC_LAG_CYC = 2;
  localparam int CMD_RESET_US = 5;
  localparam int CMD_RESET_CYC = CMD_RESET_US * CLK_MHZ;
  localparam int POR_RESET_MS = 1;
  localparam int POR_RESET_CYC = POR_RESET_MS * 1000 * CLK_MHZ;
  localparam int PAGE_PROGRAM_TIME_US = 700;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int ARRAY_LOAD_TIME_US = 25;
  localparam int ARRAY_LOAD_CYC = ARRAY_LOAD_TIME_US * CLK_MHZ;
  localparam int STROBE_CYC = 1;
endpackage : otp_host_pkg

/* File: otp_host_monitor.sv */
// Checker for the pin and register port behaviour of the OTP host controller
`timescale 1ns/1ps
`default_nettype none
module otp_host_monitor (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_re_n,
  input wire logic o_wp_n,
  input wire logic [7:0] o_io,
  input wire logic o_io_oe_n,
  input wire logic [7:0] i_io,
  input wire logic i_ready_busy_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // One latched byte: the device takes the bus at the rising write strobe
  sequence byte_s(c, a, v);
    $rose(o_we_n) && o_cle == c && o_ale == a && o_io == v;
  endsequence
  a_lock_seq: assert property (byte_s(1'b1, 1'b0, otp_host_pkg::CMD_OTP_LOCK) |->
    ##2 byte_s(1'b0, 1'b1, 8'h00) ##2 byte_s(1'b0, 1'b1, 8'h00) ##2 byte_s(1'b0, 1'b1, 8'h01)
    ##2 byte_s(1'b0, 1'b1, 8'h00) ##2 byte_s(1'b1, 1'b0, 8'h10)) else $error("lock sequence");
  a_read_seq: assert property (byte_s(1'b1, 1'b0, otp_host_pkg::CMD_OTP_READ) |->
    ##2 byte_s(1'b0, 1'b1, o_io) ##2 byte_s(1'b0, 1'b1, o_io)
    ##2 (byte_s(1'b0, 1'b1, o_io) && o_io >= 8'h02 && o_io <= 8'h0B)
    ##2 byte_s(1'b0, 1'b1, o_io) ##2 byte_s(1'b1, 1'b0, 8'h30)) else $error("read sequence");
  a_lock_poll: assert property (byte_s(1'b1, 1'b0, 8'h10) |->
    ##[2:80] byte_s(1'b1, 1'b0, otp_host_pkg::CMD_READ_STATUS)) else $error("no status after lock");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata not zero");
  a_we_pulse: assert property ($fell(o_we_n) |=> $rose(o_we_n)) else $error("write strobe width");
  a_latch_hold: assert property ($rose(o_we_n) |-> $stable(o_io) && $stable(o_cle) && $stable(o_ale))
    else $error("bus moved at latch");
  a_strobe_excl: assert property (!(!o_we_n && !o_re_n) && !(o_cle && o_ale)) else $error("strobes clash");
  a_oe_write: assert property (!o_we_n |-> !o_io_oe_n && !o_ce_n) else $error("bus not driven");
  a_oe_read: assert property (!o_re_n |-> o_io_oe_n && !o_ce_n) else $error("bus driven in read");
  a_wp_quiet: assert property ($changed(o_wp_n) |-> o_ce_n) else $error("wp moved in op");
  c_lock: cover property (byte_s(1'b1, 1'b0, otp_host_pkg::CMD_OTP_LOCK));
  c_read: cover property (byte_s(1'b1, 1'b0, otp_host_pkg::CMD_OTP_READ));
  c_irq: cover property ($rose(o_irq));
endmodule // otp_host_monitor
bind otp_host otp_host_monitor u_otp_host_monitor (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_ce_n(o_ce_n),
  .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n), .o_io(o_io),
  .o_io_oe_n(o_io_oe_n), .i_io(i_io), .i_ready_busy_n(i_ready_busy_n));
`default_nettype wire

/* File: otp_nand_model.sv */
// Behavioural model of the flash part: OTP lock, OTP read, status and reset
`timescale 1ns/1ps
`default_nettype none
module otp_nand_model (
  input wire logic i_clk,
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_ready_busy_n
);
  logic [7:0] cmd = 8'h00, last = 8'h00, page = 8'h00, stat, dout, adr [4];
  logic [15:0] col = 16'h0000;
  logic locked = 1'b0, fail = 1'b0, smode = 1'b0, first = 1'b1, we_q = 1'b1, re_q = 1'b1, ok;
  int na = 0, busy = 15;
  assign o_ready_busy_n = (busy == 0);
  assign stat = {~locked, o_ready_busy_n, o_ready_busy_n, 4'h0, fail};
  assign dout = smode ? stat : page ^ col[7:0];
  // Released bus shows the inverse of the last byte so stale data never matches
  assign o_io = (!i_ce_n && !i_re_n) ? dout : ~last;
  assign ok = i_wp_n && adr[0] == 8'h00 && adr[1] == 8'h00 && adr[2] == 8'h01 && adr[3] == 8'h00;
  // Strobe edges seen on the clock; host holds bus for a cycle after each rise
  always @(posedge i_clk)
  begin
    we_q <= i_we_n;
    re_q <= i_re_n;
    if (busy > 0) busy <= busy - 1;
    if (!i_ce_n && !i_re_n) last <= dout;
    if (!re_q && i_re_n && !smode) col <= col + 16'h0001;
    if (!we_q && i_we_n && !i_ce_n && i_ale && na < 4)
    begin
      adr[na] <= i_io;
      na <= na + 1;
    end
    if (!we_q && i_we_n && !i_ce_n && i_cle)
    begin
      na <= 0;
      case (i_io)
        otp_host_pkg::CMD_RESET: begin busy <= first ? 30 : 10; first <= 1'b0; smode <= 1'b0; end
        otp_host_pkg::CMD_READ_STATUS: smode <= 1'b1;
        otp_host_pkg::CMD_PROG_CONFIRM: if (cmd == otp_host_pkg::CMD_OTP_LOCK)
        begin
          fail <= !ok;
          locked <= locked | ok;
          busy <= (ok && !locked) ? 30 : 3;
        end
        otp_host_pkg::CMD_READ_CONFIRM: if (cmd == otp_host_pkg::CMD_OTP_READ)
        begin
          page <= adr[2];
          col <= {adr[1], adr[0]};
          busy <= 20;
          smode <= 1'b0;
        end
        otp_host_pkg::CMD_RAND_OUT_CONFIRM: begin col <= {adr[1], adr[0]}; smode <= 1'b0; end
        default: cmd <= i_io;
      endcase
    end
  end
endmodule // otp_nand_model
`default_nettype wire

/* File: test_otp_host.sv */
// Self-checking bench for the OTP host controller against the flash model
`timescale 1ns/1ps
`default_nettype none
module test_otp_host;
  logic i_clk = 1'b0, i_nrst, i_wr, i_rd, o_irq, o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n;
  logic o_io_oe_n, rb_n;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, v;
  logic [7:0] o_io, dev_io, io_w;
  int n_mismatch = 0, n_tests = 0;
  // Page, column and expected byte per row
  logic [31:0] rows [3] = '{32'h02000002, 32'h0B00050E, 32'h0700FFF8};
  assign io_w = o_io_oe_n ? dev_io : o_io;
  always #50 i_clk = ~i_clk;
  otp_host #(.POWER_WAIT(20), .POR_TIMEOUT(50), .PROG_TIMEOUT(50)) u_otp_host (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
    .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n), .o_io(o_io), .o_io_oe_n(o_io_oe_n),
    .i_io(io_w), .i_ready_busy_n(rb_n));
  otp_nand_model u_otp_nand_model (.i_clk(i_clk), .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
    .i_we_n(o_we_n), .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_io(io_w), .o_io(dev_io),
    .o_ready_busy_n(rb_n));
  task automatic end_of_test();
    $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Start an operation and poll the busy flag under a bound
  task automatic op(input logic [2:0] code, input logic wp);
    int k;
    wr(otp_host_pkg::REG_CTRL, {28'h0, code, wp});
    for (k = 0; k < 400; k++)
    begin
      rd(otp_host_pkg::REG_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    if (k == 400)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic read_rows();
    for (int r = 0; r < 3; r++)
    begin
      wr(otp_host_pkg::REG_ADDR, {8'h00, rows[r][31:8]});
      op(otp_host_pkg::OP_READ, 1'b0);
      op(otp_host_pkg::OP_DATA, 1'b0);
      rd(otp_host_pkg::REG_RDATA, v);
      chk(v, {24'h0, rows[r][7:0]});
      op(otp_host_pkg::OP_DATA, 1'b0);
      rd(otp_host_pkg::REG_RDATA, v);
      chk(v, {24'h0, rows[r][31:24] ^ (rows[r][15:8] + 8'h01)});
      wr(otp_host_pkg::REG_ADDR, {8'h00, rows[r][31:24], 16'h0010});
      op(otp_host_pkg::OP_RAND, 1'b0);
      rd(otp_host_pkg::REG_RDATA, v);
      chk(v, {24'h0, rows[r][31:24] ^ 8'h10});
      op(otp_host_pkg::OP_DATA, 1'b0);
      rd(otp_host_pkg::REG_RDATA, v);
      chk(v, {24'h0, rows[r][31:24] ^ 8'h11});
    end
  endtask
  initial
  begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1 chk({o_ce_n, o_we_n, o_re_n, o_wp_n, o_io_oe_n, o_irq}, 32'h3A);
    rd(otp_host_pkg::REG_MASK, v);
    chk(v, 32'h0);
    op(otp_host_pkg::OP_READ, 1'b0);
    rd(otp_host_pkg::REG_IRQ, v);
    chk(v, 32'h2);
    wr(otp_host_pkg::REG_MASK, 32'h7);
    op(otp_host_pkg::OP_INIT, 1'b0);
    chk(o_irq, 32'h1);
    rd(otp_host_pkg::REG_IRQ, v);
    chk(v, 32'h1);
    rd(otp_host_pkg::REG_STATUS, v);
    chk(v, 32'h4);
    chk(o_irq, 32'h0);
    read_rows();
    // Clear the sticky done bits left by the page reads
    rd(otp_host_pkg::REG_IRQ, v);
    chk(v, 32'h1);
    foreach (rows[r]) if (r < 2)
    begin
      wr(otp_host_pkg::REG_ADDR, {8'h00, r ? 8'h0C : 8'h01, 16'h0000});
      op(otp_host_pkg::OP_READ, 1'b0);
      rd(otp_host_pkg::REG_IRQ, v);
      chk(v, 32'h4);
    end
    op(otp_host_pkg::OP_LOCK, 1'b0);
    rd(otp_host_pkg::REG_IRQ, v);
    chk(v, 32'h2);
    rd(otp_host_pkg::REG_DEV_STATUS, v);
    chk(v, 32'hE1);
    op(otp_host_pkg::OP_LOCK, 1'b1);
    rd(otp_host_pkg::REG_IRQ, v);
    chk(v, 32'h1);
    rd(otp_host_pkg::REG_DEV_STATUS, v);
    chk(v, 32'h60);
    read_rows();
    op(otp_host_pkg::OP_RESET, 1'b1);
    wr(otp_host_pkg::REG_MASK, 32'h0);
    op(otp_host_pkg::OP_STATUS, 1'b1);
    chk(o_irq, 32'h0);
    rd(otp_host_pkg::REG_IRQ, v);
    chk(v, 32'h1);
    rd(otp_host_pkg::REG_DEV_STATUS, v);
    chk(v, 32'h60);
    rd(otp_host_pkg::REG_CTRL, v);
    chk(v, 32'h1);
    rd(otp_host_pkg::REG_ADDR, v);
    chk(v, 32'h00070010);
    wr(4'hF, 32'h5);
    rd(4'hF, v);
    chk(v, 32'h0);
    rd(otp_host_pkg::REG_MASK, v);
    chk(v, 32'h0);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(posedge i_clk);
    i_nrst <= 1'b1;
    // Synchroniser restarts at busy level and needs two edges to refill
    repeat (2) @(posedge i_clk);
    rd(otp_host_pkg::REG_STATUS, v);
    chk(v, 32'h0);
    end_of_test();
  end
endmodule // test_otp_host
`default_nettype wire
